// ---- inc/gport_pkg.sv ----
// package of shared constants and types for the graphics port arbiter pair
// How it works
// - no low-priority read grant while buffer full
// - master accepts grant coinciding with buffer full
// - withhold low-priority read grants until full deasserts
// - other grant types unaffected by buffer full
// - counter increments only on write grants
// - counter decrements on each sampled write irdy
// - write grant plus irdy holds counter
// - no write grant while counter at three
// - registered irdy would raise limit to four
// - target uses live controls; arbiter may register
// - master drives irdy two clocks after grant
// - master tolerates four queued grants
// - next grant waits for read last phase
// - target idles one clock write to read
// - master idles one clock read to write
// - only data bus turns around, not controls
// - master never remembers an earlier 111 grant
// - master asserts frame the clock after 111 grant
// - master drops request on final transaction
// - master holds request off three clocks after stop
// - master starts request within two clocks
// - no bus or parity error reporting
`default_nettype none
package gport_pkg;
    // grant type status codes
    typedef enum logic [2:0] {
        GT_LP_READ  = 3'b000,
        GT_HP_READ  = 3'b001,
        GT_LP_WRITE = 3'b010,
        GT_HP_WRITE = 3'b011,
        GT_START    = 3'b111
    } grant_type_t;
    localparam logic [2:0] WR_LIMIT       = 3'h3; // live irdy limit
    localparam logic [2:0] WR_LIMIT_REG   = 3'h4; // registered irdy limit
    localparam logic [2:0] CNT_RESET      = 3'h0;
    localparam logic [1:0] IRDY_DELAY     = 2'h2; // grant to irdy clocks
    localparam logic [1:0] START_WINDOW   = 2'h2; // request start within
    localparam logic [1:0] REQ_BACKOFF    = 2'h2; // req off after stop
    localparam logic [3:0] LEN_W          = 4'h4; // phase length width
    localparam bit         USE_REG_IRDY   = 1'b0; // arbiter samples live irdy
endpackage : gport_pkg
`default_nettype wire

// ---- inc/gport_if.sv ----
// interface joining arbiter and graphics master, active-low pins as _n
`default_nettype none
interface gport_if;
    logic       gnt_n;
    logic [2:0] grant_type_status;
    logic       lp_read_buffer_full_n;
    logic       irdy_n;
    logic       req_n;
    logic       frame_n;
    logic       stop_n;
    logic       ad_oe_tgt;
    logic       ad_oe_mst;
    modport arbiter (output gnt_n, output grant_type_status, output stop_n,
                     output ad_oe_tgt, input lp_read_buffer_full_n,
                     input irdy_n, input req_n, input frame_n);
    modport master (input gnt_n, input grant_type_status, input stop_n,
                    input ad_oe_tgt, output lp_read_buffer_full_n,
                    output irdy_n, output req_n, output frame_n,
                    output ad_oe_mst);
endinterface : gport_if
`default_nettype wire

// ---- rtl/gport_master.sv ----
// graphics master end: grant pipeline, irdy timing, request handling
`default_nettype none
module gport_master (
    input  wire logic     clk_sys,
    input  wire logic     rst,
    gport_if.master       bus,
    input  wire logic     buf_full,
    input  wire logic     want_bus,
    input  wire logic     last_txn,
    output logic          wr_accept,
    output logic          rd_accept,
    output logic          pci_start
);
    logic [2:0] wpipe_q;      // write grants awaiting irdy
    logic       rbf_q;
    logic       irdy_q;
    logic       frame_q;
    logic       req_q;
    logic [1:0] backoff_q;
    logic       rd_q;
    logic       gnt;
    assign gnt = ~bus.gnt_n;

    // ************************************************
    // grant pipeline, irdy two clocks after write grant
    // ************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wpipe_q <= 3'h0;
        end else begin
            wpipe_q <= {wpipe_q[1:0], gnt & bus.grant_type_status[1]
                        & (bus.grant_type_status != gport_pkg::GT_START)};
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irdy_q    <= 1'b0;
            wr_accept <= 1'b0;
        end else begin
            irdy_q    <= wpipe_q[0];
            wr_accept <= wpipe_q[0];
        end
    end

    // read accept and buffer full; granted read still taken
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rbf_q     <= 1'b0;
            rd_q      <= 1'b0;
            rd_accept <= 1'b0;
        end else begin
            rbf_q     <= buf_full;
            rd_q      <= gnt & ~bus.grant_type_status[1];
            rd_accept <= gnt & ~bus.grant_type_status[1];
        end
    end

    // ************************************************
    // start on current 111 grant only, request control
    // ************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            frame_q   <= 1'b0;
            pci_start <= 1'b0;
        end else begin
            // start only on live grant, frame the next clock
            frame_q   <= gnt && bus.grant_type_status == gport_pkg::GT_START
                         && req_q && bus.irdy_n && !frame_q;
            pci_start <= gnt && bus.grant_type_status == gport_pkg::GT_START
                         && req_q && bus.irdy_n && !frame_q;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            req_q     <= 1'b0;
            backoff_q <= 2'h0;
        end else if (!bus.stop_n) begin
            req_q     <= 1'b0;
            backoff_q <= gport_pkg::REQ_BACKOFF;
        end else if (backoff_q != 2'h0) begin
            req_q     <= 1'b0;
            backoff_q <= backoff_q - 2'h1;
        end else begin
            req_q     <= want_bus & ~(frame_q & last_txn);
        end
    end

    assign bus.lp_read_buffer_full_n = ~rbf_q;
    assign bus.irdy_n                = ~irdy_q;
    assign bus.frame_n               = ~frame_q;
    assign bus.req_n                 = ~req_q;
    // master drives data bus for writes; idle clock after reads
    assign bus.ad_oe_mst             = irdy_q & ~rd_q;
    // no error detection on this port
endmodule : gport_master
`default_nettype wire

// ---- rtl/gport_arbiter.sv ----
// arbiter end: grant scheduling, buffer-full hold-off, write grant counter
`default_nettype none
module gport_arbiter (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    gport_if.arbiter         bus,
    input  wire logic        lp_rd_pend,
    input  wire logic        hp_rd_pend,
    input  wire logic        wr_pend,
    input  wire logic [3:0]  rd_len,
    input  wire logic        retry,
    output logic [2:0]       wr_outstanding
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_TURN = 2'b10
    } arb_state_t;

    arb_state_t  state_q;
    logic        gnt_q;
    logic [2:0]  gtype_q;
    logic [2:0]  wcnt_q;
    logic [3:0]  rd_left_q;
    logic        last_wr_q;
    logic        ad_oe_q;
    logic        stop_q;
    logic        irdy_s;
    logic        irdy_reg_q;
    logic [2:0]  limit;
    logic        rbf;
    logic        may_grant;
    logic        gnt_wr, gnt_lp, gnt_hp, gnt_st;

    // ************************************************
    // grant decision
    // ************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) irdy_reg_q <= 1'b0;
        else     irdy_reg_q <= ~bus.irdy_n;
    end
    // live irdy by default; registered copy needs one more slot
    assign irdy_s = gport_pkg::USE_REG_IRDY ? irdy_reg_q : ~bus.irdy_n;
    assign limit  = gport_pkg::USE_REG_IRDY ? gport_pkg::WR_LIMIT_REG
                                            : gport_pkg::WR_LIMIT;
    assign rbf    = ~bus.lp_read_buffer_full_n;
    // next grant only in idle or read last phase
    assign may_grant = (state_q == ST_IDLE) ||
                       (state_q == ST_READ && rd_left_q <= 4'h1);
    always_comb begin
        gnt_hp = may_grant && hp_rd_pend;
        gnt_wr = may_grant && !gnt_hp && wr_pend && wcnt_q < limit;
        gnt_lp = may_grant && !gnt_hp && !gnt_wr && lp_rd_pend && !rbf;
        gnt_st = may_grant && !gnt_hp && !gnt_wr && !gnt_lp && !bus.req_n
                 && !stop_q;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gnt_q   <= 1'b0;
            gtype_q <= gport_pkg::GT_START;
        end else begin
            gnt_q   <= gnt_hp | gnt_wr | gnt_lp | gnt_st;
            gtype_q <= gnt_hp ? gport_pkg::GT_HP_READ :
                       gnt_wr ? gport_pkg::GT_LP_WRITE :
                       gnt_lp ? gport_pkg::GT_LP_READ : gport_pkg::GT_START;
        end
    end

    // ************************************************
    // write grant counter
    // ************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wcnt_q <= gport_pkg::CNT_RESET;
        end else if (gnt_wr && !irdy_s) begin
            wcnt_q <= wcnt_q + 3'h1;
        end else if (!gnt_wr && irdy_s && wcnt_q != 3'h0) begin
            wcnt_q <= wcnt_q - 3'h1;
        end // grant with irdy holds
    end
    always_ff @(posedge clk_sys) begin
        if (rst) wr_outstanding <= 3'h0;
        else     wr_outstanding <= wcnt_q;
    end

    // ************************************************
    // read phase tracking and turnaround
    // ************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q   <= ST_IDLE;
            rd_left_q <= 4'h0;
            last_wr_q <= 1'b0;
            ad_oe_q   <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE, ST_READ: begin
                    if (gnt_hp || gnt_lp) begin
                        if (last_wr_q || irdy_s) begin
                            state_q <= ST_TURN;
                            ad_oe_q <= 1'b0;
                        end else begin
                            state_q <= ST_READ;
                            ad_oe_q <= 1'b1;
                        end
                        rd_left_q <= rd_len;
                        last_wr_q <= 1'b0;
                    end else begin
                        if (gnt_wr) last_wr_q <= 1'b1;
                        if (rd_left_q > 4'h1) rd_left_q <= rd_left_q - 4'h1;
                        else begin
                            state_q <= ST_IDLE;
                            ad_oe_q <= 1'b0;
                        end
                    end
                end
                ST_TURN: begin
                    // one idle on data bus only; grant keeps its owner
                    state_q <= ST_READ;
                    ad_oe_q <= 1'b1;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) stop_q <= 1'b0;
        else     stop_q <= retry & ~bus.frame_n;
    end

    assign bus.gnt_n             = ~gnt_q;
    assign bus.grant_type_status = gtype_q;
    assign bus.ad_oe_tgt         = ad_oe_q;
    assign bus.stop_n            = ~stop_q;
    // no parity or error reporting
endmodule : gport_arbiter
`default_nettype wire

// ---- sim/gport_asserts.sv ----
// assertion checker on the graphics port interface signals
`default_nettype none
module gport_asserts (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       gnt_n,
    input wire logic [2:0] grant_type_status,
    input wire logic       lp_read_buffer_full_n,
    input wire logic       irdy_n,
    input wire logic       ad_oe_tgt,
    input wire logic       ad_oe_mst,
    input wire logic       req_n,
    input wire logic       stop_n
);
    logic [2:0] wr_cnt_q;
    logic [2:0] wr_cnt_d;
    logic       wr_gnt;
    // ************
    // write grant mirror
    // ************
    assign wr_gnt = !gnt_n && grant_type_status[2:1] == 2'h1;
    assign wr_cnt_d = wr_cnt_q + {2'h0, wr_gnt} - {2'h0, !irdy_n};
    // counts grants seen minus irdy seen
    always_ff @(posedge clk_sys) begin
        if (rst) wr_cnt_q <= 3'h0;
        else wr_cnt_q <= wr_cnt_d;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_wr_grant; wr_gnt; endsequence
    sequence s_irdy; !irdy_n; endsequence
    a_lp_full_block: assert property (!lp_read_buffer_full_n |=>
        !(!gnt_n && grant_type_status == gport_pkg::GT_LP_READ)) else $error("lp grant when full");
    a_wr_limit: assert property (wr_cnt_q <= 3'h3) else $error("too many write grants");
    a_irdy_follow: assert property (s_wr_grant |-> ##2 s_irdy) else $error("irdy late");
    a_irdy_pair: assert property (s_irdy |-> wr_cnt_q != 3'h0) else $error("stray irdy");
    a_tgt_turn: assert property ($fell(ad_oe_mst) |-> !ad_oe_tgt) else $error("no idle");
    a_mst_turn: assert property ($fell(ad_oe_tgt) |-> !ad_oe_mst) else $error("no idle");
    a_reset_idle: assert property ($fell(rst) |-> gnt_n && irdy_n) else $error("bad reset");
    a_one_driver: assert property (!(ad_oe_tgt && ad_oe_mst)) else $error("bus clash");
    a_req_backoff: assert property (!stop_n |=> req_n ##1 req_n) else $error("req kept");
endmodule : gport_asserts
`default_nettype wire

// ---- sim/test_graphics_port_data_grant_arbiter.sv ----
// self-checking bench for the arbiter and master pair
`default_nettype none
module test_graphics_port_data_grant_arbiter;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic       lp_rd_pend = 1'b0, hp_rd_pend = 1'b0, wr_pend = 1'b0, retry = 1'b0;
    logic       buf_full = 1'b0, want_bus = 1'b0, last_txn = 1'b0;
    logic [3:0] rd_len = 4'h1;
    logic [2:0] wr_outstanding;
    logic       wr_accept, rd_accept, pci_start;
    logic [7:0] n_wr = 8'h00, n_lp = 8'h00, n_hp = 8'h00, n_acc = 8'h00, n_pci = 8'h00;
    logic [7:0] lp0, hp0;
    logic [7:0] n_rda = 8'h00, n_stop = 8'h00;
    int         n_mismatch = 0, num_checks = 0;
    gport_if bus_i ();
    gport_arbiter gport_arbiter_i (.clk_sys(clk_sys), .rst(rst), .bus(bus_i.arbiter),
        .lp_rd_pend(lp_rd_pend), .hp_rd_pend(hp_rd_pend), .wr_pend(wr_pend),
        .rd_len(rd_len), .retry(retry), .wr_outstanding(wr_outstanding));
    gport_master gport_master_i (.clk_sys(clk_sys), .rst(rst), .bus(bus_i.master),
        .buf_full(buf_full), .want_bus(want_bus), .last_txn(last_txn),
        .wr_accept(wr_accept), .rd_accept(rd_accept), .pci_start(pci_start));
    gport_asserts gport_asserts_i (.clk_sys(clk_sys), .rst(rst), .gnt_n(bus_i.gnt_n),
        .grant_type_status(bus_i.grant_type_status), .irdy_n(bus_i.irdy_n),
        .lp_read_buffer_full_n(bus_i.lp_read_buffer_full_n),
        .ad_oe_tgt(bus_i.ad_oe_tgt), .ad_oe_mst(bus_i.ad_oe_mst),
        .req_n(bus_i.req_n), .stop_n(bus_i.stop_n));
    // clock at 8 ns
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    // counts grants by kind and master pulses
    always @(posedge clk_sys) begin
        if (!rst && bus_i.gnt_n === 1'b0) begin
            if (bus_i.grant_type_status[2:1] === 2'h1) n_wr++;
            if (bus_i.grant_type_status === gport_pkg::GT_LP_READ) n_lp++;
            if (bus_i.grant_type_status === gport_pkg::GT_HP_READ) n_hp++;
        end
        if (!rst && wr_accept === 1'b1) n_acc++;
        if (!rst && pci_start === 1'b1) n_pci++;
        if (!rst && rd_accept === 1'b1) n_rda++;
        if (!rst && bus_i.stop_n === 1'b0) n_stop++;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude
    // watchdog
    initial begin
        #(4000 * 8);
        n_mismatch++;
        conclude();
    end
    // main sequence
    initial begin
        tick(16);
        rst <= 1'b0;
        tick(2);
        chk({5'h00, wr_outstanding}, 8'h00);
        wr_pend <= 1'b1;
        tick(8);
        wr_pend <= 1'b0;
        tick(10);
        chk({7'h00, n_wr != 8'h00}, 8'h01);
        chk(n_acc, n_wr);
        chk({5'h00, wr_outstanding}, 8'h00);
        buf_full <= 1'b1;
        tick(4);
        lp0 = n_lp;
        hp0 = n_hp;
        lp_rd_pend <= 1'b1;
        tick(10);
        chk(n_lp, lp0);
        hp_rd_pend <= 1'b1;
        wr_pend <= 1'b1;
        tick(6);
        hp_rd_pend <= 1'b0;
        wr_pend <= 1'b0;
        tick(8);
        chk({7'h00, n_hp != hp0}, 8'h01);
        chk(n_acc, n_wr);
        buf_full <= 1'b0;
        tick(10);
        lp_rd_pend <= 1'b0;
        chk({7'h00, n_lp != lp0}, 8'h01);
        tick(10);
        want_bus <= 1'b1;
        last_txn <= 1'b1;
        tick(20);
        want_bus <= 1'b0;
        last_txn <= 1'b0;
        tick(4);
        chk({7'h00, n_pci != 8'h00}, 8'h01);
        chk({7'h00, bus_i.req_n}, 8'h01);
        // retried starts force the request off for three clocks
        retry <= 1'b1;
        want_bus <= 1'b1;
        tick(20);
        retry <= 1'b0;
        want_bus <= 1'b0;
        tick(4);
        chk({7'h00, n_stop != 8'h00}, 8'h01);
        chk(n_rda, n_lp + n_hp);
        wr_pend <= 1'b1;
        tick(2);
        rst <= 1'b1;
        wr_pend <= 1'b0;
        tick(2);
        rst <= 1'b0;
        tick(1);
        chk({5'h00, wr_outstanding}, 8'h00);
        chk({7'h00, bus_i.gnt_n}, 8'h01);
        conclude();
    end
endmodule : test_graphics_port_data_grant_arbiter
`default_nettype wire
